//--- rtl/gmbs_sched.sv
// message budget scheduler: receive decode budget and publication transmit budget
// assumes a quarter-cycle tick pulse, synchronous rst, a 40 MHz clk
`timescale 1ns/100ps
`include "gmbs_params.svh"
// Operation
// - If arrivals in an interval total 80 points or fewer, all are decoded and applied that interval.
// - A received message with an unchanged state number is a repeat and costs only 8 points.
// - Beyond 80 points in an interval, the excess waits and is handled in the next interval.
// - Up to eight publications are supported, each fed from any source.
// - After configuration every enabled publication sends one message.
// - Each interval changed publications are sent first, then those whose timer expired.
// - Each publication counts content changes, and a change sends it and restarts its timer at 4 ms.
// - Unchanged content is resent at intervals from 4 ms doubling up to a configured maximum.
// - Each sent message carries a time to live of three intervals, or two once at the maximum.
// - The cost of a publication is fixed when it is configured.
// - No more than 40 transmit points are spent per interval; the rest is deferred.
// - Transmit cost is 8 points plus 1 point per data item, and unsent messages cost nothing.
// - Sending stops when the next message would pass 40 points and resumes next interval.
// - Every received header costs eight points.
// - Each mapped Boolean in a received body costs one point, unmapped ones nothing.
module gmbs_sched
  import gmbs_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `GMBS_MS_NS / `GMBS_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [3:0]  rx_sub,
  input  wire logic [15:0] rx_stnum,
  input  wire logic [6:0]  rx_body_pts,
  input  wire logic [15:0] rx_vbits,
  output logic             vb_valid,
  output logic [3:0]       vb_sub,
  output logic [15:0]      vb_data,
  output logic [7:0]       rx_pts_used,
  input  wire logic        cfg_wr,
  input  wire logic [2:0]  cfg_idx,
  input  wire logic        cfg_enable,
  input  wire logic [5:0]  cfg_items,
  input  wire logic [15:0] cfg_max_ms,
  input  wire logic        cfg_commit,
  input  wire logic [7:0]  pub_change,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [2:0]       tx_pub,
  output logic [15:0]      tx_stnum,
  output logic [17:0]      tx_ttl_ms,
  output logic [7:0]       tx_cost,
  output logic [7:0]       tx_pts_used
);
  localparam int RXW = $bits(gmbs_rx_msg_t);

  gmbs_state_t  q;
  gmbs_state_t  d;
  gmbs_rx_msg_t head;
  logic         rx_repeat;
  logic [7:0]   rx_cost;
  logic         rx_take;
  logic         send_done;
  logic [7:0]   restart;
  logic [7:0]   sent;
  logic [7:0]   due;
  logic [7:0][15:0] ivl;
  logic [7:0][15:0] nxt;
  logic [7:0]   cand_cost;
  logic         cand_fits;

  gmbs_stream_if #(.W(RXW)) in_s ();
  gmbs_stream_if #(.W(RXW)) out_s ();

  assign in_s.valid = rx_valid;
  assign in_s.data  = {rx_sub, rx_stnum, rx_body_pts, rx_vbits};
  assign rx_ready   = in_s.ready;

  // deferred arrivals wait here; a full fifo stalls the sender
  gmbs_fifo #(
    .W     (RXW),
    .DEPTH (`GMBS_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk (clk),
    .rst (rst),
    .wr  (in_s),
    .rd  (out_s)
  );

  genvar g;
  generate
    for (g = 0; g < `GMBS_NPUB; g++)
    begin : g_pub
      gmbs_pub_timer u_timer (
        .clk         (clk),
        .rst         (rst),
        .ms_tick     (q.ms_tick),
        .restart     (restart[g]),
        .sent        (sent[g]),
        .max_ms      (q.max_ms),
        .due         (due[g]),
        .interval_ms (ivl[g]),
        .next_ms     (nxt[g])
      );
      assign restart[g] = send_done && q.tx_is_chg && (q.tx_pub == 3'(g));
      assign sent[g]    = send_done && !q.tx_is_chg && (q.tx_pub == 3'(g));
    end
  endgenerate

  // time to live from the interval that follows this send
  function automatic logic [17:0] ttl_of(input logic [15:0] iv, input logic [15:0] mx);
    logic [17:0] w;
    w = {2'b00, iv};
    ttl_of = (iv >= mx) ? (w << 1) : ((w << 1) + w);
  endfunction

  assign head        = gmbs_rx_msg_t'(out_s.data);
  assign vb_valid    = q.vb_valid;
  assign vb_sub      = q.vb_sub;
  assign vb_data     = q.vb_data;
  assign rx_pts_used = q.rx_pts;
  assign tx_valid    = q.tx_valid;
  assign tx_pub      = q.tx_pub;
  assign tx_stnum    = q.tx_stnum;
  assign tx_ttl_ms   = q.tx_ttl;
  assign tx_cost     = q.tx_cost;
  assign tx_pts_used = q.tx_pts;
  assign send_done   = (q.st == GMBS_SEND) && q.tx_valid && tx_ready;

  always_comb
  begin
    rx_repeat = q.seen[head.sub] && (q.last_stnum[head.sub] == head.stnum);
    rx_cost   = rx_repeat ? `GMBS_HDR_PTS : `GMBS_HDR_PTS + {1'b0, head.body_pts};
    rx_take   = out_s.valid && !tick && ((q.rx_pts + rx_cost) <= `GMBS_RX_BUDGET);
    out_s.ready = rx_take;
  end

  always_comb
  begin
    d          = q;
    d.vb_valid = 1'b0;
    d.ms_tick  = 1'b0;
    cand_cost  = q.cost[q.idx];
    cand_fits  = (q.tx_pts + cand_cost) <= `GMBS_TX_BUDGET;

    if (q.ms_cnt == 16'(MS_CYCLES - 1))
    begin
      d.ms_cnt  = '0;
      d.ms_tick = 1'b1;
    end
    else
      d.ms_cnt = q.ms_cnt + 16'h0001;

    // receive side
    if (tick)
      d.rx_pts = '0;
    else if (rx_take)
    begin
      d.rx_pts               = q.rx_pts + rx_cost;
      d.seen[head.sub]       = 1'b1;
      d.last_stnum[head.sub] = head.stnum;
      if (!rx_repeat)
      begin
        d.vb_valid = 1'b1;
        d.vb_sub   = head.sub;
        d.vb_data  = head.vbits;
      end
    end

    // configuration
    if (cfg_wr)
    begin
      d.en[cfg_idx]   = cfg_enable;
      d.cost[cfg_idx] = `GMBS_HDR_PTS + (`GMBS_ITEM_PTS * {2'b00, cfg_items});
    end

    // transmit scan
    case (q.st)
      GMBS_IDLE:
      begin
        if (tick)
        begin
          d.st  = GMBS_CHG;
          d.idx = '0;
        end
      end
      GMBS_CHG:
      begin
        if (q.chg_pend[q.idx] && q.en[q.idx])
        begin
          if (cand_fits)
          begin
            d.tx_valid  = 1'b1;
            d.tx_pub    = q.idx;
            d.tx_stnum  = q.pub_stnum[q.idx];
            d.tx_ttl    = ttl_of(`GMBS_INIT_IVL_MS, q.max_ms);
            d.tx_cost   = cand_cost;
            d.tx_is_chg = 1'b1;
            d.ret_st    = GMBS_CHG;
            d.st        = GMBS_SEND;
          end
          else
            d.st = GMBS_IDLE;
        end
        else if (q.idx == `GMBS_LAST_PUB)
        begin
          d.st  = GMBS_RTX;
          d.idx = '0;
        end
        else
          d.idx = q.idx + 3'h1;
      end
      GMBS_RTX:
      begin
        if (due[q.idx] && q.en[q.idx] && !q.chg_pend[q.idx])
        begin
          if (cand_fits)
          begin
            d.tx_valid  = 1'b1;
            d.tx_pub    = q.idx;
            d.tx_stnum  = q.pub_stnum[q.idx];
            d.tx_ttl    = ttl_of(nxt[q.idx], q.max_ms);
            d.tx_cost   = cand_cost;
            d.tx_is_chg = 1'b0;
            d.ret_st    = GMBS_RTX;
            d.st        = GMBS_SEND;
          end
          else
            d.st = GMBS_IDLE;
        end
        else if (q.idx == `GMBS_LAST_PUB)
          d.st = GMBS_IDLE;
        else
          d.idx = q.idx + 3'h1;
      end
      GMBS_SEND:
      begin
        if (tx_ready)
        begin
          d.tx_valid = 1'b0;
          d.tx_pts   = q.tx_pts + q.tx_cost;
          if (q.tx_is_chg)
            d.chg_pend[q.tx_pub] = 1'b0;
          if (q.idx != `GMBS_LAST_PUB)
          begin
            d.st  = q.ret_st;
            d.idx = q.idx + 3'h1;
          end
          else if (q.ret_st == GMBS_CHG)
          begin
            d.st  = GMBS_RTX;
            d.idx = '0;
          end
          else
            d.st = GMBS_IDLE;
        end
      end
      default:
        d.st = GMBS_IDLE;
    endcase

    if (tick)
      d.tx_pts = '0;

    if (cfg_commit)
    begin
      d.max_ms   = cfg_max_ms;
      d.chg_pend = q.chg_pend | d.en;
    end

    // a change arriving with its own send still leaves the flag set
    for (int i = 0; i < `GMBS_NPUB; i++)
    begin
      if (pub_change[i])
      begin
        d.pub_stnum[i] = q.pub_stnum[i] + 16'h0001;
        d.chg_pend[i]  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q        <= '0;
      q.st     <= GMBS_IDLE;
      q.ret_st <= GMBS_IDLE;
    end
    else
      q <= d;
  end
endmodule

//--- rtl/gmbs_params.svh
// constants for the message budget scheduler
// assumes a 40 MHz clock and an external quarter-cycle interval tick
`ifndef GMBS_PARAMS_SVH
`define GMBS_PARAMS_SVH

`define GMBS_CLK_NS       32'h00000019
`define GMBS_MS_NS        32'h000f4240
`define GMBS_HDR_PTS      8'h08
`define GMBS_ITEM_PTS     8'h01
`define GMBS_RX_BUDGET    8'h50
`define GMBS_TX_BUDGET    8'h28
`define GMBS_INIT_IVL_MS  16'h0004
`define GMBS_NPUB         8
`define GMBS_NSUB         16
`define GMBS_FIFO_DEPTH   4
`define GMBS_LAST_PUB     3'h7

`endif

//--- rtl/gmbs_pkg.sv
// types shared by the message budget scheduler modules
// assumes gmbs_params.svh is compiled alongside
package gmbs_pkg;

  typedef enum logic [1:0] {
    GMBS_IDLE = 2'b00,
    GMBS_CHG  = 2'b01,
    GMBS_RTX  = 2'b10,
    GMBS_SEND = 2'b11
  } gmbs_tx_state_t;

  typedef struct packed {
    logic [15:0] interval_ms;
    logic [15:0] elapsed_ms;
    logic        due;
  } gmbs_timer_t;

  typedef struct packed {
    logic [3:0]  sub;
    logic [15:0] stnum;
    logic [6:0]  body_pts;
    logic [15:0] vbits;
  } gmbs_rx_msg_t;

  typedef struct packed {
    logic [15:0]       ms_cnt;
    logic              ms_tick;
    logic [7:0]        rx_pts;
    logic [15:0]       seen;
    logic [15:0][15:0] last_stnum;
    logic              vb_valid;
    logic [3:0]        vb_sub;
    logic [15:0]       vb_data;
    logic [7:0]        tx_pts;
    gmbs_tx_state_t    st;
    gmbs_tx_state_t    ret_st;
    logic [2:0]        idx;
    logic [7:0]        en;
    logic [7:0][7:0]   cost;
    logic [15:0]       max_ms;
    logic [7:0]        chg_pend;
    logic [7:0][15:0]  pub_stnum;
    logic              tx_valid;
    logic [2:0]        tx_pub;
    logic [15:0]       tx_stnum;
    logic [17:0]       tx_ttl;
    logic [7:0]        tx_cost;
    logic              tx_is_chg;
  } gmbs_state_t;

endpackage

//--- rtl/gmbs_stream_if.sv
// valid/ready word stream between scheduler modules
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface gmbs_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- rtl/gmbs_fifo.sv
// small valid/ready fifo holding received message descriptors
// assumes synchronous active-high reset
`timescale 1ns/100ps
module gmbs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic   clk,
  input  wire logic   rst,
  gmbs_stream_if.snk  wr,
  gmbs_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_st_t;

  fifo_st_t q;
  fifo_st_t d;
  logic     push;
  logic     pop;

  assign wr.ready = (q.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (q.cnt != '0);
  assign rd.data  = q.mem[q.rp];

  always_comb
  begin
    d    = q;
    push = wr.valid && wr.ready;
    pop  = rd.valid && rd.ready;
    if (push)
    begin
      d.mem[q.wp] = wr.data;
      d.wp        = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + AW'(1);
    end
    if (pop)
      d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + AW'(1);
    if (push && !pop)
      d.cnt = q.cnt + (AW+1)'(1);
    else if (pop && !push)
      d.cnt = q.cnt - (AW+1)'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end
endmodule

//--- rtl/gmbs_pub_timer.sv
// doubling retransmission timer of one publication
// assumes a one-cycle millisecond strobe and synchronous reset
`timescale 1ns/100ps
`include "gmbs_params.svh"
module gmbs_pub_timer
  import gmbs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ms_tick,
  input  wire logic        restart,
  input  wire logic        sent,
  input  wire logic [15:0] max_ms,
  output logic             due,
  output logic [15:0]      interval_ms,
  output logic [15:0]      next_ms
);
  gmbs_timer_t q;
  gmbs_timer_t d;
  logic [16:0] dbl;

  assign due         = q.due;
  assign interval_ms = q.interval_ms;

  always_comb
  begin
    d       = q;
    dbl     = {q.interval_ms, 1'b0};
    next_ms = (dbl >= {1'b0, max_ms}) ? max_ms : dbl[15:0];
    if (restart)
    begin
      d.interval_ms = `GMBS_INIT_IVL_MS;
      d.elapsed_ms  = '0;
      d.due         = 1'b0;
    end
    else if (sent)
    begin
      d.interval_ms = next_ms;
      d.elapsed_ms  = '0;
      d.due         = 1'b0;
    end
    else if (ms_tick && !q.due)
    begin
      d.elapsed_ms = q.elapsed_ms + 16'h0001;
      if (d.elapsed_ms >= q.interval_ms)
        d.due = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q             <= '0;
      q.interval_ms <= `GMBS_INIT_IVL_MS;
    end
    else
      q <= d;
  end
endmodule

//--- test/gmbs_peer.sv
// peer relay model: takes published messages after a varying wait
// assumes tx_valid and its fields hold until the edge that sees tx_ready
`timescale 1ns/100ps
module gmbs_peer (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tx_valid,
  output logic      tx_ready
);
  logic [1:0] wait_q;
  logic [1:0] gap_q;
  // ready is a one-cycle accept; the wait differs from message to message
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_ready <= 1'b0;
      wait_q   <= 2'h0;
      gap_q    <= 2'h0;
    end
    else if (tx_valid && !tx_ready)
    begin
      tx_ready <= wait_q == 2'h0;
      wait_q   <= wait_q - 2'h1;
    end
    else
    begin
      tx_ready <= 1'b0;
      wait_q   <= gap_q;
      gap_q    <= gap_q + 2'(tx_ready);
    end
  end
endmodule

//--- test/gmbs_sched_chk.sv
// port assertions of the message budget scheduler
// assumes one clock and synchronous active-high rst
`timescale 1ns/100ps
module gmbs_sched_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        tick,
  input wire logic        vb_valid,
  input wire logic [7:0]  rx_pts_used,
  input wire logic [15:0] cfg_max_ms,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [2:0]  tx_pub,
  input wire logic [17:0] tx_ttl_ms,
  input wire logic [7:0]  tx_cost,
  input wire logic [7:0]  tx_pts_used
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    tx_valid && tx_ready && !tick;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  a_rx_budget_cap: assert property (rx_pts_used <= 8'h50)
    else $error("receive points over budget");
  a_tx_budget_cap: assert property (tx_pts_used <= 8'h28)
    else $error("transmit points over budget");
  a_tx_fits_budget: assert property (tx_valid |-> 9'(tx_pts_used) + 9'(tx_cost) <= 9'h028)
    else $error("message sent past budget");
  a_tx_charge: assert property (s_take |=> tx_pts_used == $past(tx_pts_used) + $past(tx_cost))
    else $error("send not charged its cost");
  a_tick_clears: assert property (tick |=> rx_pts_used == 8'h00 && tx_pts_used == 8'h00)
    else $error("budgets not cleared at tick");
  a_tx_fields_hold: assert property (s_stall |=> tx_valid && $stable(tx_pub) && $stable(tx_cost)
    && $stable(tx_ttl_ms))
    else $error("message dropped or changed while stalled");
  a_tx_cost_range: assert property (tx_valid |-> tx_cost >= 8'h08 && tx_cost <= 8'h47)
    else $error("cost outside header plus items");
  a_ttl_form: assert property (tx_valid |-> tx_ttl_ms % 3 == 0 || tx_ttl_ms == 2 * cfg_max_ms)
    else $error("time to live not three or two intervals");
  a_rx_header_cost: assert property (!$past(tick) && rx_pts_used != $past(rx_pts_used)
    |-> rx_pts_used >= $past(rx_pts_used) + 8'h08)
    else $error("receive charge below header cost");
  a_vb_charged: assert property (vb_valid |-> rx_pts_used >= 8'h08)
    else $error("data applied without charge");
endmodule
bind gmbs_sched gmbs_sched_chk gmbs_sched_chk_i (.clk, .rst, .tick, .vb_valid, .rx_pts_used,
  .cfg_max_ms, .tx_valid, .tx_ready, .tx_pub, .tx_ttl_ms, .tx_cost, .tx_pts_used);

//--- test/test_goose_message_budget_scheduler.sv
// self-checking bench: drives receive and configuration, peer model takes sends
// assumes the checker bind is compiled; tick every 60 cycles, 1 ms = 10 cycles
`timescale 1ns/100ps
module test_goose_message_budget_scheduler;
  logic        clk = 1'b0, rst = 1'b1, tick = 1'b0, rx_valid = 1'b0, cfg_wr = 1'b0;
  logic        cfg_enable = 1'b1, cfg_commit = 1'b0, chg_on = 1'b0;
  logic        rx_ready, vb_valid, tx_valid, tx_ready;
  logic [2:0]  cfg_idx = 3'h0, tx_pub;
  logic [3:0]  rx_sub = 4'h0, vb_sub;
  logic [5:0]  cfg_items = 6'h00;
  logic [6:0]  rx_body_pts = 7'h00;
  logic [6:0]  bod[8] = '{7'h08, 7'h0c, 7'h02, 7'h08, 7'h0a, 7'h02, 7'h0c, 7'h02};
  logic [7:0]  rx_pts_used, tx_cost, tx_pts_used, pub_change = 8'h00, pend = 8'h00;
  logic [7:0]  tick_pts = 8'h00;
  logic [15:0] rx_stnum = 16'h0000, rx_vbits = 16'h0000, vb_data, tx_stnum, nx;
  logic [15:0] cfg_max_ms = 16'h0010, seen = 16'h0000;
  logic [15:0] last[16], stn[8], ivl[8];
  logic [17:0] tx_ttl_ms;
  logic [19:0] exp_vb, rx_q[$];
  logic [31:0] rnd = 32'h87cdf42e, chg_r = 32'h87cdf42e;
  int          miscompares = 0, n_tests = 0, rtx_n = 0, cyc = 0;
  gmbs_sched #(.MS_CYCLES(10)) gmbs_sched_i (.clk, .rst, .tick, .rx_valid, .rx_ready, .rx_sub,
    .rx_stnum, .rx_body_pts, .rx_vbits, .vb_valid, .vb_sub, .vb_data, .rx_pts_used, .cfg_wr,
    .cfg_idx, .cfg_enable, .cfg_items, .cfg_max_ms, .cfg_commit, .pub_change, .tx_valid,
    .tx_ready, .tx_pub, .tx_stnum, .tx_ttl_ms, .tx_cost, .tx_pts_used);
  gmbs_peer gmbs_peer_i (.clk, .rst, .tx_valid, .tx_ready);
  always #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expect_done(input string what, input logic ok);
    check(what, 1, ok);
    if (!ok)
      complete_run();
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_tick;
    int k;
    for (k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (tick)
      begin
        tick_pts = rx_pts_used;
        break;
      end
    end
    #1;
    expect_done("tick_seen", k < 100);
  endtask
  // holds rx_valid high on exit so back-to-back calls never re-raise it
  task automatic send_rx(input logic [3:0] s, input logic [15:0] n, input logic [6:0] b);
    int k;
    rnd = lfsr(rnd);
    rx_valid = 1'b1;
    rx_sub = s;
    rx_stnum = n;
    rx_body_pts = b;
    rx_vbits = rnd[15:0];
    for (k = 0; k < 300; k++)
    begin
      @(posedge clk);
      if (rx_ready)
        break;
    end
    #1;
    expect_done("rx_accept", k < 300);
    if (!seen[s] || last[s] !== n)
      rx_q.push_back({s, rnd[15:0]});
    seen[s] = 1'b1;
    last[s] = n;
  endtask
  // interval tick, and change pulses at a tick only while no message is waiting
  always @(posedge clk)
  begin
    #1;
    cyc++;
    tick = cyc % 60 == 0;
    if (tick)
      chg_r = lfsr(chg_r);
    pub_change = tick && chg_on && !tx_valid ? chg_r[7:0] & chg_r[15:8] : 8'h00;
  end
  always @(posedge clk)
  begin
    if (!rst && vb_valid)
    begin
      exp_vb = rx_q.size() > 0 ? rx_q.pop_front() : 'x;
      check("vb_word", exp_vb, {vb_sub, vb_data});
    end
    if (!rst && tx_valid && tx_ready)
    begin
      nx = pend[tx_pub] ? 16'h0004 : ivl[tx_pub] << 1;
      nx = nx > cfg_max_ms ? cfg_max_ms : nx;
      if (!pend[tx_pub])
      begin
        rtx_n++;
        check("tx_order", 0, pend);
      end
      check("tx_cost", 10 + tx_pub, tx_cost);
      check("tx_stnum", stn[tx_pub], tx_stnum);
      check("tx_ttl", nx == cfg_max_ms ? 2 * nx : 3 * nx, tx_ttl_ms);
      ivl[tx_pub] = nx;
      pend[tx_pub] = 1'b0;
    end
    for (int i = 0; i < 8; i++)
      if (pub_change[i])
      begin
        stn[i] = stn[i] + 16'h0001;
        pend[i] = 1'b1;
      end
    if (cfg_commit)
      pend = 8'hff;
  end
  initial
  begin
    foreach (stn[i])
      stn[i] = 16'h0000;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      cfg_wr = 1'b1;
      cfg_idx = 3'(i);
      cfg_items = 6'(i + 2);
      step();
    end
    cfg_wr = 1'b0;
    cfg_commit = 1'b1;
    step();
    cfg_commit = 1'b0;
    for (int k = 0; k < 1000 && pend != 8'h00; k++)
      step();
    check("init_sends", 0, pend);
    $display("test tx_init done");
    chg_on = 1'b1;
    repeat (1500) step();
    chg_on = 1'b0;
    repeat (600) step();
    check("retransmits", 1, rtx_n > 20);
    $display("test tx_traffic done");
    wait_tick();
    for (int i = 0; i < 5; i++)
      send_rx(4'(i + 1), 16'h0001, bod[i]);
    rx_valid = 1'b0;
    wait_tick();
    check("fit_left", 0, rx_q.size());
    check("fit_pts", 8'h50, tick_pts);
    for (int i = 0; i < 8; i++)
      send_rx(4'(i + 1), 16'h0001, bod[i]);
    rx_valid = 1'b0;
    wait_tick();
    check("repeat_left", 0, rx_q.size());
    check("repeat_pts", 8'h50, tick_pts);
    $display("test rx_fit done");
    for (int i = 0; i < 8; i++)
      send_rx(4'(i + 9), 16'h0002, 7'h10 | 7'(rnd[3:0]));
    rx_valid = 1'b0;
    for (int k = 0; k < 300 && rx_q.size() > 0; k++)
      step();
    expect_done("rx_drain", rx_q.size() == 0);
    $display("test rx_over done");
    complete_run();
  end
endmodule
